// ### rtl/irq_ctrl_pkg.sv
// Constants shared by the interrupt controller and its helper modules.
// Assumes source numbers run from 1 to 25; number 0 is reset.
package irq_ctrl_pkg;

  // ==========================================================================
  // Source set
  localparam int          NUM_SRC       = 25;
  localparam int          ID_W          = 5;
  localparam int          FIRST_MASK    = 4;
  localparam logic [25:0] NMI_MASK      = 26'h000000E;
  localparam logic [25:0] PIN_MASK      = 26'h01F0100;
  localparam int          TIMEBASE_SRC  = 5;

  // ==========================================================================
  // Priority levels: six 8-bit level registers, four 2-bit fields each.
  localparam int          LVL_REGS      = 6;
  localparam int          LVL_REG_W     = 8;
  localparam int          LVL_W         = 2;
  localparam int          LVL_BUS_W     = LVL_REGS * LVL_REG_W;

  // ==========================================================================
  // Service rank: 0 idle, 1 to 4 maskable level plus one, 5 non-maskable.
  localparam int          RANK_W        = 3;
  localparam logic [2:0]  RANK_IDLE     = 3'h0;
  localparam logic [2:0]  RANK_NMI      = 3'h5;

  // ==========================================================================
  // Vector tables.
  localparam int          VEC_W         = 16;
  localparam logic [15:0] VEC_HIGH_BASE = 16'hFFFE;
  localparam logic [15:0] VEC_LOW_BASE  = 16'h01FE;
  localparam logic [15:0] VEC_RESET     = 16'h0000;

  // ==========================================================================
  // Nesting stack.
  localparam int          STACK_DEPTH   = 8;
  localparam int          SP_W          = 4;

endpackage : irq_ctrl_pkg

// ### rtl/irq_pin_sync.sv
// Three-stage synchroniser for an external request pin with rising detect.
// Assumes the pin is asynchronous to core_clk_i.
module irq_pin_sync (
  // Clock, reset and enable
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  // Pin and detected edge
  input  wire logic pin_i,
  output logic      rise_o
);

  logic s1_reg, s2_reg, s3_reg, level_reg, rise_reg;
  logic s1_next, s2_next, s3_next, level_next, rise_next;

  // ==========================================================================
  // A change counts only once the second and third stages agree.
  always_comb begin
    s1_next    = pin_i;
    s2_next    = s1_reg;
    s3_next    = s2_reg;
    level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
    rise_next  = level_next & ~level_reg;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
    end else if (ce_i) begin
      s1_reg    <= s1_next;
      s2_reg    <= s2_next;
      s3_reg    <= s3_next;
      level_reg <= level_next;
      rise_reg  <= rise_next;
    end
  end

  assign rise_o = rise_reg;

endmodule : irq_pin_sync

// ### rtl/irq_nest_stack.sv
// Small stack of service ranks for nested interrupt service.
// Assumes push and pop never arrive in the same cycle; pushes when full
// and pops when empty are ignored.
module irq_nest_stack (
  // Clock, reset and enable
  input  wire logic                              core_clk_i,
  input  wire logic                              rst_b_i,
  input  wire logic                              ce_i,
  // Stack control
  input  wire logic                              push_i,
  input  wire logic                              pop_i,
  input  wire logic [irq_ctrl_pkg::RANK_W-1:0]   rank_i,
  // Stack state
  output logic      [irq_ctrl_pkg::RANK_W-1:0]   top_o,
  output logic      [irq_ctrl_pkg::SP_W-1:0]     depth_o
);

  logic [irq_ctrl_pkg::RANK_W-1:0] mem [irq_ctrl_pkg::STACK_DEPTH];
  logic [irq_ctrl_pkg::RANK_W-1:0] top_reg, top_next;
  logic [irq_ctrl_pkg::SP_W-1:0]   sp_reg, sp_next;
  logic                            do_push, do_pop;

  // ==========================================================================
  // The top entry lives in a register; older entries sit in the array.
  always_comb begin
    do_push  = push_i &&
               (sp_reg < irq_ctrl_pkg::SP_W'(irq_ctrl_pkg::STACK_DEPTH));
    do_pop   = pop_i && (sp_reg != '0);
    top_next = top_reg;
    sp_next  = sp_reg;
    if (do_push) begin
      top_next = rank_i;
      sp_next  = sp_reg + 1'b1;
    end else if (do_pop) begin
      top_next = mem[sp_reg[2:0] - 3'h1];
      sp_next  = sp_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (ce_i && do_push) begin
      mem[sp_reg[2:0]] <= top_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      top_reg <= irq_ctrl_pkg::RANK_IDLE;
      sp_reg  <= '0;
    end else if (ce_i) begin
      top_reg <= top_next;
      sp_reg  <= sp_next;
    end
  end

  assign top_o   = top_reg;
  assign depth_o = sp_reg;

endmodule : irq_nest_stack

// ### rtl/irq_priority_ctrl.sv
// Prioritised interrupt controller for an 8-bit core.
// Assumes the core acks only while irq_req_o is high and pulses
// irq_return_i once at the end of each accepted handler.
module irq_priority_ctrl (
  // Clock, reset and enable
  input  wire logic                                core_clk_i,
  input  wire logic                                rst_b_i,
  input  wire logic                                ce_i,
  // Request sources; pins in PIN_MASK are asynchronous, others are pulses
  input  wire logic [irq_ctrl_pkg::NUM_SRC:1]      irq_line_i,
  // Software control
  input  wire logic                                master_irq_enable_i,
  input  wire logic [irq_ctrl_pkg::NUM_SRC:1]      source_enable_flag_i,
  input  wire logic [irq_ctrl_pkg::LVL_BUS_W-1:0]  priority_level_regs_i,
  input  wire logic                                vector_base_select_i,
  input  wire logic [irq_ctrl_pkg::NUM_SRC:1]      latch_clear_i,
  // Core handshake
  input  wire logic                                irq_ack_i,
  input  wire logic                                irq_return_i,
  output logic                                     irq_req_o,
  output logic      [irq_ctrl_pkg::VEC_W-1:0]      vector_o,
  output logic      [irq_ctrl_pkg::ID_W-1:0]       irq_id_o,
  // Status
  output logic      [irq_ctrl_pkg::NUM_SRC:1]      request_latch_o,
  output logic      [irq_ctrl_pkg::RANK_W-1:0]     service_rank_o,
  output logic      [irq_ctrl_pkg::SP_W-1:0]       nest_depth_o
);

  // ==========================================================================
  // Decoding helpers

  // Rank of a source under the current level registers.
  function automatic logic [irq_ctrl_pkg::RANK_W-1:0] rank_of(
    input int                                       src,
    input logic [irq_ctrl_pkg::LVL_BUS_W-1:0]       lvls
  );
    logic [irq_ctrl_pkg::LVL_W-1:0] lvl;
    lvl = '0;
    if (irq_ctrl_pkg::NMI_MASK[src]) begin
      rank_of = irq_ctrl_pkg::RANK_NMI;
    end else begin
      lvl = lvls[irq_ctrl_pkg::LVL_W*(src-irq_ctrl_pkg::FIRST_MASK)
                 +: irq_ctrl_pkg::LVL_W];
      rank_of = {1'b0, lvl} + 3'h1;
    end
  endfunction : rank_of

  // Vector address of a source from the selected table.
  function automatic logic [irq_ctrl_pkg::VEC_W-1:0] vector_of(
    input logic [irq_ctrl_pkg::ID_W-1:0] src,
    input logic                          low_table
  );
    logic [irq_ctrl_pkg::VEC_W-1:0] base;
    base = low_table ? irq_ctrl_pkg::VEC_LOW_BASE
                     : irq_ctrl_pkg::VEC_HIGH_BASE;
    vector_of = base - {10'h000, src, 1'b0};
  endfunction : vector_of

  // ==========================================================================
  // Request capture

  logic [irq_ctrl_pkg::NUM_SRC:1] set_pulse;

  for (genvar k = 1; k <= irq_ctrl_pkg::NUM_SRC; k++) begin : g_src
    if (irq_ctrl_pkg::PIN_MASK[k]) begin : g_pin
      irq_pin_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .ce_i       (ce_i),
        .pin_i      (irq_line_i[k]),
        .rise_o     (set_pulse[k])
      );
    end else begin : g_int
      assign set_pulse[k] = irq_line_i[k];
    end
  end

  // ==========================================================================
  // Nesting stack

  logic [irq_ctrl_pkg::RANK_W-1:0] top_rank;
  logic [irq_ctrl_pkg::RANK_W-1:0] push_rank;
  logic [irq_ctrl_pkg::SP_W-1:0]   depth;
  logic                            accept;

  irq_nest_stack u_stack (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .push_i     (accept),
    .pop_i      (irq_return_i),
    .rank_i     (push_rank),
    .top_o      (top_rank),
    .depth_o    (depth)
  );

  // ==========================================================================
  // Latches and arbitration

  logic [irq_ctrl_pkg::NUM_SRC:1]    latch_reg, latch_next;
  logic                              req_reg, req_next;
  logic [irq_ctrl_pkg::ID_W-1:0]     id_reg, id_next;
  logic [irq_ctrl_pkg::VEC_W-1:0]    vec_reg, vec_next;
  logic [irq_ctrl_pkg::NUM_SRC:1]    eligible;
  logic [irq_ctrl_pkg::NUM_SRC:1]    ack_clear;
  logic [irq_ctrl_pkg::RANK_W-1:0]   best_rank;
  logic [irq_ctrl_pkg::RANK_W-1:0]   cand_rank;
  logic [irq_ctrl_pkg::ID_W-1:0]     best_id;
  logic                              found;

  // A latched request may be withdrawn by software after it was offered.
  assign irq_req_o = req_reg && latch_reg[id_reg];
  assign accept    = irq_req_o && irq_ack_i;

  always_comb begin
    push_rank = rank_of(int'(id_reg), priority_level_regs_i);
    ack_clear = '0;
    if (accept) begin
      ack_clear[id_reg] = 1'b1;
    end
    // Set wins over any clear arriving in the same cycle.
    latch_next = (latch_reg & ~latch_clear_i & ~ack_clear)
               | set_pulse;
  end

  always_comb begin
    eligible  = '0;
    best_rank = top_rank;
    best_id   = '0;
    found     = 1'b0;
    cand_rank = '0;
    for (int k = 1; k <= irq_ctrl_pkg::NUM_SRC; k++) begin
      // Non-maskable sources ignore both enables.
      eligible[k] = latch_reg[k] && !ack_clear[k] &&
                    (irq_ctrl_pkg::NMI_MASK[k] ||
                     (master_irq_enable_i &&
                      source_enable_flag_i[k]));
      cand_rank = rank_of(k, priority_level_regs_i);
      // Strictly above the service rank; ties keep the lower number.
      if (eligible[k] && cand_rank > best_rank) begin
        best_rank = cand_rank;
        best_id   = irq_ctrl_pkg::ID_W'(k);
        found     = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Offer to the core
  // The offer is dropped for one cycle after each acceptance so that the
  // stack top and the latch reflect the new service before the next pick.

  always_comb begin
    req_next = found && !accept;
    id_next  = id_reg;
    vec_next = vec_reg;
    if (found && !accept) begin
      id_next  = best_id;
      vec_next = vector_of(best_id, vector_base_select_i);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_reg <= '0;
      req_reg   <= 1'b0;
      id_reg    <= '0;
      vec_reg   <= irq_ctrl_pkg::VEC_RESET;
    end else if (ce_i) begin
      latch_reg <= latch_next;
      req_reg   <= req_next;
      id_reg    <= id_next;
      vec_reg   <= vec_next;
    end
  end

  // ==========================================================================
  // Outputs

  assign vector_o        = vec_reg;
  assign irq_id_o        = id_reg;
  assign request_latch_o = latch_reg;
  assign service_rank_o  = top_rank;
  assign nest_depth_o    = depth;

endmodule : irq_priority_ctrl

// ### testbench/irq_priority_ctrl_monitor.sv
// Concurrent checks on the interrupt controller's ports.
// Assumes it is bound to irq_priority_ctrl and sees only its ports.
module irq_priority_ctrl_monitor (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  // Inputs
  input wire logic [25:1] irq_line_i,
  input wire logic        master_irq_enable_i,
  input wire logic        vector_base_select_i,
  input wire logic [25:1] latch_clear_i,
  input wire logic        irq_ack_i,
  // Outputs
  input wire logic        irq_req_o,
  input wire logic [15:0] vector_o,
  input wire logic [4:0]  irq_id_o,
  input wire logic [25:1] request_latch_o,
  input wire logic [2:0]  service_rank_o,
  input wire logic [3:0]  nest_depth_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Helpers
  // Pins pass a synchroniser, so only same-clock requests are timed here.
  logic [25:1] fresh;
  assign fresh = irq_line_i & ~irq_ctrl_pkg::PIN_MASK[25:1];
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_accept;
    irq_req_o && irq_ack_i;
  endsequence
  sequence s_accept_nmi;
    s_accept ##0 (irq_id_o < 5'h04);
  endsequence
  // ========
  // Checks
  a_ack_drops_req: assert property (s_accept |=> !irq_req_o)
    else $error("offer stayed up after ack");
  a_ack_clears_latch: assert property (
    s_accept ##0 (!irq_line_i[irq_id_o] && !fresh[irq_id_o] &&
    !irq_ctrl_pkg::PIN_MASK[irq_id_o])
    |=> !request_latch_o[$past(irq_id_o)])
    else $error("accepted latch not cleared");
  a_nmi_rank: assert property (
    s_accept_nmi |=> service_rank_o == 3'h5)
    else $error("non-maskable service rank wrong");
  a_depth_push: assert property (
    s_accept ##0 (nest_depth_o < 4'h8)
    |=> nest_depth_o == $past(nest_depth_o) + 4'h1)
    else $error("nest depth not pushed");
  a_vector_map: assert property (irq_req_o |-> vector_o ==
    ($past(vector_base_select_i) ? 16'h01FE : 16'hFFFE) -
    {10'h000, irq_id_o, 1'b0})
    else $error("vector does not match source");
  a_mask_gate: assert property (
    irq_req_o && irq_id_o > 5'h03 |-> $past(master_irq_enable_i))
    else $error("maskable offer with master off");
  a_latch_set: assert property (
    fresh != '0 |=> (request_latch_o & $past(fresh)) == $past(fresh))
    else $error("request did not set latch");
  a_latch_holds: assert property (
    latch_clear_i == '0 && !irq_ack_i |=>
    (request_latch_o & $past(request_latch_o)) == $past(request_latch_o))
    else $error("latch lost without clear");
endmodule : irq_priority_ctrl_monitor

bind irq_priority_ctrl irq_priority_ctrl_monitor i_irq_priority_ctrl_monitor (
  .core_clk_i, .rst_b_i, .irq_line_i, .master_irq_enable_i,
  .vector_base_select_i, .latch_clear_i, .irq_ack_i, .irq_req_o, .vector_o,
  .irq_id_o, .request_latch_o, .service_rank_o, .nest_depth_o);

// ### testbench/cpu_core_model.sv
// Behavioural core that accepts offered interrupts and ends handlers.
// Assumes it shares core_clk_i and rst_b_i with the controller.
module cpu_core_model (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  // Bench control
  input  wire logic accept_en_i,
  input  wire logic slow_i,
  input  wire logic end_i,
  // Controller side
  input  wire logic irq_req_i,
  output logic      irq_ack_o,
  output logic      irq_return_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_cnt;
  logic       want;
  assign want = irq_req_i && accept_en_i && !irq_ack_o;
  // Acks a standing offer at once, or after three cycles when slow.
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_ack_o <= 1'b0;
      irq_return_o <= 1'b0;
      wait_cnt <= 2'h0;
    end else begin
      irq_return_o <= end_i && !irq_ack_o;
      irq_ack_o <= want && (!slow_i || wait_cnt == 2'h2);
      wait_cnt <= (want && slow_i && wait_cnt != 2'h2) ?
                  wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : cpu_core_model

// ### testbench/tb.sv
// Self-checking bench for the interrupt controller and a model core.
// Assumes the package, controller, core model and checker are compiled.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Signals
  logic        core_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [25:1] irq_line_i = '0;
  logic        master_irq_enable_i = 1'b1;
  logic [25:1] source_enable_flag_i = '1;
  logic [47:0] priority_level_regs_i = '0;
  logic        vector_base_select_i = 1'b0;
  logic [25:1] latch_clear_i = '0;
  logic        accept_en = 1'b0;
  logic        slow = 1'b0;
  logic        end_pulse = 1'b0;
  logic        irq_ack_i;
  logic        irq_return_i;
  logic        irq_req_o;
  logic [15:0] vector_o;
  logic [4:0]  irq_id_o;
  logic [25:1] request_latch_o;
  logic [2:0]  service_rank_o;
  logic [3:0]  nest_depth_o;
  int          failures = 0;
  int          checks = 0;
  int          a;
  int          b;
  int          w;

  always #4 core_clk_i = ~core_clk_i;

  irq_priority_ctrl i_irq_priority_ctrl (
    .core_clk_i, .rst_b_i, .ce_i(1'b1), .irq_line_i, .master_irq_enable_i,
    .source_enable_flag_i, .priority_level_regs_i, .vector_base_select_i,
    .latch_clear_i, .irq_ack_i, .irq_return_i, .irq_req_o, .vector_o,
    .irq_id_o, .request_latch_o, .service_rank_o, .nest_depth_o);
  cpu_core_model i_cpu_core_model (
    .core_clk_i, .rst_b_i, .accept_en_i(accept_en), .slow_i(slow),
    .end_i(end_pulse), .irq_req_i(irq_req_o), .irq_ack_o(irq_ack_i),
    .irq_return_o(irq_return_i));

  // ========
  // Expectations and helpers
  function automatic logic [15:0] exp_vec(int k);
    return (vector_base_select_i ? 16'h01FE : 16'hFFFE) - 16'(2 * k);
  endfunction : exp_vec
  function automatic logic [2:0] exp_rank(int k);
    if (k < 4) return 3'h5;
    return {1'b0, priority_level_regs_i[2*(k-4)+:2]} + 3'h1;
  endfunction : exp_rank
  function automatic int win(int x, int y);
    if (exp_rank(x) != exp_rank(y)) return exp_rank(x) > exp_rank(y) ? x : y;
    return x < y ? x : y;
  endfunction : win
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic fire(int k, int j);
    irq_line_i[k] = 1'b1;
    if (j > 0) irq_line_i[j] = 1'b1;
    @(negedge core_clk_i);
    // Pins must stand until two synchroniser stages agree on the new level.
    irq_line_i = irq_line_i & irq_ctrl_pkg::PIN_MASK[25:1];
    repeat (2) @(negedge core_clk_i);
    irq_line_i = '0;
  endtask : fire
  task automatic serve(int k);
    logic [3:0] d;
    repeat (12) if (!irq_req_o) @(negedge core_clk_i);
    check("irq_id_o", irq_id_o, k);
    check("vector_o", vector_o, exp_vec(k));
    check("request_latch_o", request_latch_o[k], 1'b1);
    d = nest_depth_o;
    accept_en = 1'b1;
    repeat (8) if (nest_depth_o === d) @(negedge core_clk_i);
    accept_en = 1'b0;
    check("service_rank_o", service_rank_o, exp_rank(k));
    check("nest_depth_o", nest_depth_o, d + 4'h1);
    check("request_latch_o", request_latch_o[k], 1'b0);
  endtask : serve
  task automatic ret();
    end_pulse = 1'b1;
    @(negedge core_clk_i);
    end_pulse = 1'b0;
    repeat (2) @(negedge core_clk_i);
  endtask : ret
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    failures++;
    final_report();
  end

  // ========
  // Scenarios
  initial begin
    void'($urandom(32'hFC9DCF77));
    repeat (2) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    check("irq_req_o", irq_req_o, 1'b0);
    check("request_latch_o", request_latch_o, '0);
    for (int k = 1; k <= 25; k++) begin
      vector_base_select_i = k[0];
      priority_level_regs_i = 48'({$urandom, $urandom});
      fire(k, 0);
      serve(k);
      ret();
    end
    master_irq_enable_i = 1'b0;
    fire(irq_ctrl_pkg::TIMEBASE_SRC, 0);
    repeat (6) @(negedge core_clk_i);
    check("irq_req_o", irq_req_o, 1'b0);
    fire(2, 0);
    serve(2);
    master_irq_enable_i = 1'b1;
    source_enable_flag_i[5] = 1'b0;
    ret();
    check("irq_req_o", irq_req_o, 1'b0);
    source_enable_flag_i[5] = 1'b1;
    serve(5);
    ret();
    for (int t = 0; t < 20; t++) begin
      do a = 4 + $urandom_range(21); while (irq_ctrl_pkg::PIN_MASK[a]);
      do b = 4 + $urandom_range(21);
      while (b == a || irq_ctrl_pkg::PIN_MASK[b]);
      slow = t[0];
      priority_level_regs_i = 48'({$urandom, $urandom});
      if (t < 4) priority_level_regs_i[2*(b-4)+:2] =
        priority_level_regs_i[2*(a-4)+:2];
      w = win(a, b);
      fire(a, b);
      serve(w);
      ret();
      serve(a + b - w);
      ret();
    end
    priority_level_regs_i = '0;
    priority_level_regs_i[11:10] = 2'h3;
    fire(7, 0);
    serve(7);
    fire(9, 0);
    serve(9);
    fire(1, 0);
    serve(1);
    fire(3, 0);
    repeat (6) @(negedge core_clk_i);
    check("irq_req_o", irq_req_o, 1'b0);
    ret();
    serve(3);
    repeat (3) ret();
    check("nest_depth_o", nest_depth_o, 4'h0);
    final_report();
  end
endmodule : tb
